// ---- design/snv_defines.svh ----
// Constants for the serial nonvolatile memory slave: opcodes, fields, pins
`ifndef SNV_DEFINES_SVH
`define SNV_DEFINES_SVH

// Array geometry: 8192 bytes, 13-bit byte address
`define SNV_ADDR_W 13
`define SNV_MEM_DEPTH 8192
`define SNV_ADDR_HI_W 5

// Command byte encodings
`define SNV_OP_WRSR 8'h01
`define SNV_OP_WRITE 8'h02
`define SNV_OP_READ 8'h03
`define SNV_OP_WRDI 8'h04
`define SNV_OP_RDSR 8'h05
`define SNV_OP_WREN 8'h06

// Status byte field positions
`define SNV_ST_STATUS_PROTECT_ENABLE_BIT 7
`define SNV_ST_BP_HI 3
`define SNV_ST_BP_LO 2
`define SNV_ST_WEL 1

// Block protect codes
`define SNV_BP_NONE 2'h0
`define SNV_BP_QUARTER 2'h1
`define SNV_BP_HALF 2'h2
`define SNV_BP_ALL 2'h3

// Pin vector positions and their idle levels at reset
`define SNV_NPINS 5
`define SNV_PIN_SCK 0
`define SNV_PIN_SI 1
`define SNV_PIN_CS_N 2
`define SNV_PIN_WP_N 3
`define SNV_PIN_HOLD_N 4
`define SNV_PIN_RST 5'h1C

`endif

// ---- design/snv_pkg.sv ----
// Types shared by the serial nonvolatile memory slave
package snv_pkg;
  typedef logic [7:0] snv_byte_t;
  typedef logic [12:0] snv_addr_t;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CMD,
    ST_ADDR,
    ST_WDATA,
    ST_RDATA,
    ST_WSR,
    ST_RSR,
    ST_IGNORE
  } snv_state_e;
endpackage

// ---- design/snv_pins_if.sv ----
// Filtered pin levels and edge pulses passed from the synchroniser
`timescale 1ns/1ps
interface snv_pins_if;
  logic [4:0] lvl;  // Settled pin levels
  logic [4:0] rise; // One-cycle pulse on a settled rising change
  logic [4:0] fall; // One-cycle pulse on a settled falling change
  modport src (output lvl, output rise, output fall);
  modport dst (input lvl, input rise, input fall);
endinterface

// ---- design/snv_pin_sync.sv ----
// Three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
`include "snv_defines.svh"
module snv_pin_sync (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Raw pins
  input wire logic [4:0] pin_i,
  // Filtered result
  snv_pins_if.src pins
);
  import snv_pkg::*;

  genvar g;
  generate
    for (g = 0; g < `SNV_NPINS; g++) begin : g_pin
      logic [2:0] st_q, st_d;   // Stage 0 feeds only stage 1
      logic lvl_q, lvl_d;       // Accepted level
      logic rise_q, rise_d;
      logic fall_q, fall_d;
      // Idle level of this pin, taken at reset
      localparam logic RST_LVL = 1'((`SNV_PIN_RST >> g) & 5'h01);

      // A change counts only once stages one and two agree
      always_comb begin
        st_d = {st_q[1:0], pin_i[g]};
        lvl_d = lvl_q;
        if (st_q[1] == st_q[2]) begin
          lvl_d = st_q[2];
        end
        rise_d = lvl_d & ~lvl_q;
        fall_d = ~lvl_d & lvl_q;
      end

      // Reset to the pin's idle level so no false edge at release
      always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          st_q <= {3{RST_LVL}};
          lvl_q <= RST_LVL;
          rise_q <= 1'h0;
          fall_q <= 1'h0;
        end else begin
          st_q <= st_d;
          lvl_q <= lvl_d;
          rise_q <= rise_d;
          fall_q <= fall_d;
        end
      end

      assign pins.lvl[g] = lvl_q;
      assign pins.rise[g] = rise_q;
      assign pins.fall[g] = fall_q;
    end
  endgenerate
endmodule

// ---- design/snv_spi_mem.sv ----
// SPI slave serial nonvolatile memory: 8K x 8 array with status register
`timescale 1ns/1ps
`include "snv_defines.svh"
module snv_spi_mem (
  // Clock and power-on reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // SPI pins from the master
  input wire logic sck_i,
  input wire logic si_i,
  input wire logic cs_n_i,
  input wire logic wp_n_i,
  input wire logic hold_n_i,
  // Serial output pin and its enable
  output logic so_o,
  output logic so_oe_o,
  // Observed state
  output snv_pkg::snv_byte_t status_o,
  output logic mode3_o
);
  import snv_pkg::*;

  // Settled pins from the synchroniser
  snv_pins_if pins ();

  snv_pin_sync u_sync (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .pin_i({hold_n_i, wp_n_i, cs_n_i, si_i, sck_i}),
    .pins(pins)
  );

  // Storage array, nonvolatile, so it has no reset
  snv_byte_t mem [`SNV_MEM_DEPTH];

  snv_state_e state_q, state_d;   // Transfer phase
  logic sel_q, sel_d;             // Device selected
  logic [2:0] cnt_q, cnt_d;       // Bits taken in the current byte
  snv_byte_t sh_q, sh_d;          // Input shift register
  snv_byte_t out_q, out_d;        // Byte being returned
  snv_addr_t addr_q, addr_d;      // Current byte address
  logic abyte_q, abyte_d;         // Second address byte due
  logic rd_q, rd_d;               // Memory command is a read
  logic wel_q, wel_d;             // Write enable latch
  logic status_protect_enable_bit_q, status_protect_enable_bit_d;           // status_protect_enable_bit
  logic [1:0] bp_q, bp_d;         // Block protect field
  logic mode3_q, mode3_d;         // Mode chosen at select
  logic drv_q, drv_d;             // First read bit has been driven
  logic so_q, so_d;
  logic oe_q, oe_d;
  logic stat_q, stat_d;           // Unused flag kept low
  logic mem_we;                   // Array write strobe
  snv_byte_t byte_in;             // Byte completed on this rise
  logic hold_ok;                  // Pause input released
  logic ev_rise, ev_fall;         // Usable clock edges
  logic sel_start;                // Select just went active

  // Upper quarter, upper half or whole array by code
  function automatic logic blk_prot(input snv_addr_t a,
                                    input logic [1:0] bp);
    logic r;
    r = 1'h0;
    case (bp)
      `SNV_BP_QUARTER: r = (a[12:11] == 2'h3);
      `SNV_BP_HALF: r = a[12];
      `SNV_BP_ALL: r = 1'h1;
      default: r = 1'h0;
    endcase
    return r;
  endfunction

  // Status byte as software reads it
  function automatic snv_byte_t status_byte(input logic status_protect_enable_bit,
                                            input logic [1:0] bp,
                                            input logic wel);
    snv_byte_t s;
    s = 8'h00;
    s[`SNV_ST_STATUS_PROTECT_ENABLE_BIT] = status_protect_enable_bit;
    s[`SNV_ST_BP_HI:`SNV_ST_BP_LO] = bp;
    s[`SNV_ST_WEL] = wel;
    return s;
  endfunction

  // Pause masks all clock and select activity
  assign hold_ok = pins.lvl[`SNV_PIN_HOLD_N];
  assign ev_rise = pins.rise[`SNV_PIN_SCK] & sel_q & hold_ok;
  assign ev_fall = pins.fall[`SNV_PIN_SCK] & sel_q & hold_ok;
  assign byte_in = {sh_q[6:0], pins.lvl[`SNV_PIN_SI]};
  // Select is only followed while not paused
  assign sel_d = hold_ok ? ~pins.lvl[`SNV_PIN_CS_N] : sel_q;
  assign sel_start = sel_d & ~sel_q;

  // Next-state logic of the whole transfer engine
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    out_d = out_q;
    addr_d = addr_q;
    abyte_d = abyte_q;
    rd_d = rd_q;
    wel_d = wel_q;
    status_protect_enable_bit_d = status_protect_enable_bit_q;
    bp_d = bp_q;
    mode3_d = mode3_q;
    drv_d = drv_q;
    so_d = so_q;
    stat_d = 1'h0;
    mem_we = 1'h0;
    if (sel_start) begin
      // Fresh selection: the next byte is a command
      state_d = ST_CMD;
      cnt_d = 3'h0;
      abyte_d = 1'h0;
      drv_d = 1'h0;
      mode3_d = pins.lvl[`SNV_PIN_SCK];
    end else if (!sel_d) begin
      state_d = ST_IDLE;
      drv_d = 1'h0;
    end else if (ev_rise) begin
      // Capture one bit, MSB first
      sh_d = byte_in;
      cnt_d = cnt_q + 3'h1;
      if (cnt_q == 3'h7) begin
        case (state_q)
          ST_CMD: begin
            case (byte_in)
              `SNV_OP_WREN: begin
                wel_d = 1'h1;
                state_d = ST_IGNORE;
              end
              `SNV_OP_WRDI: begin
                wel_d = 1'h0;
                state_d = ST_IGNORE;
              end
              `SNV_OP_RDSR: begin
                out_d = status_byte(status_protect_enable_bit_q, bp_q, wel_q);
                state_d = ST_RSR;
              end
              `SNV_OP_WRSR: state_d = ST_WSR;
              `SNV_OP_READ: begin
                rd_d = 1'h1;
                state_d = ST_ADDR;
              end
              `SNV_OP_WRITE: begin
                rd_d = 1'h0;
                state_d = ST_ADDR;
              end
              // Unknown command: sit out the rest of the selection
              default: state_d = ST_IGNORE;
            endcase
          end
          ST_ADDR: begin
            if (!abyte_q) begin
              // Top three bits of the first byte are dropped
              addr_d[12:8] = byte_in[4:0];
              abyte_d = 1'h1;
            end else begin
              addr_d[7:0] = byte_in;
              if (rd_q) begin
                out_d = mem[{addr_q[12:8], byte_in}];
                state_d = ST_RDATA;
              end else begin
                state_d = ST_WDATA;
              end
            end
          end
          ST_WDATA: begin
            // Committed at once; no busy time follows
            mem_we = wel_q & ~blk_prot(addr_q, bp_q);
            addr_d = addr_q + 13'h0001;
          end
          ST_RDATA: begin
            out_d = mem[addr_q + 13'h0001];
            addr_d = addr_q + 13'h0001;
          end
          ST_WSR: begin
            // Pin only guards the status register when enabled
            if (wel_q && !(status_protect_enable_bit_q && !pins.lvl[`SNV_PIN_WP_N])) begin
              status_protect_enable_bit_d = byte_in[`SNV_ST_STATUS_PROTECT_ENABLE_BIT];
              bp_d = byte_in[`SNV_ST_BP_HI:`SNV_ST_BP_LO];
            end
            state_d = ST_IGNORE;
          end
          ST_RSR: out_d = status_byte(status_protect_enable_bit_q, bp_q, wel_q);
          default: state_d = state_q;
        endcase
      end
    end else if (ev_fall && (state_q == ST_RDATA || state_q == ST_RSR)) begin
      // Next output bit appears on the falling edge
      so_d = out_q[~cnt_q];
      drv_d = 1'h1;
    end
    // Driven only in a read phase, selected and not paused
    oe_d = sel_d & hold_ok & drv_d &
           (state_d == ST_RDATA || state_d == ST_RSR);
  end

  // Engine registers; reset is the power-on reset
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= ST_IDLE;
      sel_q <= 1'h0;
      cnt_q <= 3'h0;
      sh_q <= 8'h00;
      out_q <= 8'h00;
      addr_q <= 13'h0000;
      abyte_q <= 1'h0;
      rd_q <= 1'h0;
      wel_q <= 1'h0;
      status_protect_enable_bit_q <= 1'h0;
      bp_q <= 2'h0;
      mode3_q <= 1'h0;
      drv_q <= 1'h0;
      so_q <= 1'h0;
      oe_q <= 1'h0;
      stat_q <= 1'h0;
    end else begin
      state_q <= state_d;
      sel_q <= sel_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      out_q <= out_d;
      addr_q <= addr_d;
      abyte_q <= abyte_d;
      rd_q <= rd_d;
      wel_q <= wel_d;
      status_protect_enable_bit_q <= status_protect_enable_bit_d;
      bp_q <= bp_d;
      mode3_q <= mode3_d;
      drv_q <= drv_d;
      so_q <= so_d;
      oe_q <= oe_d;
      stat_q <= stat_d;
    end
  end

  // Array write port; contents survive reset on purpose
  always_ff @(posedge clk_sys_i) begin
    if (mem_we) begin
      mem[addr_q] <= byte_in;
    end
  end

  // Status output is registered so every output is a flop
  snv_byte_t status_q;
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      status_q <= 8'h00;
    end else begin
      status_q <= status_byte(status_protect_enable_bit_d, bp_d, wel_d);
    end
  end

  assign so_o = so_q;
  assign so_oe_o = oe_q;
  assign status_o = status_q;
  assign mode3_o = mode3_q;

  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  pause_output_off_a: assert property (
    !pins.lvl[`SNV_PIN_HOLD_N] |=> !so_oe_o)
    else $error("output driven while paused");
  standby_output_off_a: assert property (
    pins.lvl[`SNV_PIN_CS_N] && pins.lvl[`SNV_PIN_HOLD_N] |=> !so_oe_o)
    else $error("output driven while deselected");
  out_on_fall_a: assert property (
    $changed(so_o) |-> $past(pins.fall[`SNV_PIN_SCK]))
    else $error("output changed without falling clock");
  in_on_rise_a: assert property (
    $changed(sh_q) |-> $past(pins.rise[`SNV_PIN_SCK]))
    else $error("input shifted without rising clock");
  write_needs_latch_a: assert property (
    mem_we |-> wel_q && !blk_prot(addr_q, bp_q) && cnt_q == 3'h7)
    else $error("array write not allowed");
  write_addr_step_a: assert property (
    mem_we |=> addr_q == $past(addr_q) + 13'h0001 ##1
      mem[$past(addr_q, 2)] == $past(byte_in, 2))
    else $error("written byte not stored");
  status_guard_a: assert property (
    state_q == ST_WSR && ev_rise && status_protect_enable_bit_q && !pins.lvl[`SNV_PIN_WP_N]
    |=> $stable(status_protect_enable_bit_q) && $stable(bp_q))
    else $error("guarded status register changed");
  mode_pick_a: assert property (
    sel_start |=> mode3_o == $past(pins.lvl[`SNV_PIN_SCK]))
    else $error("mode not taken from clock level");
  pause_freeze_a: assert property (
    !pins.lvl[`SNV_PIN_HOLD_N] |=> $stable(state_q) && $stable(cnt_q))
    else $error("transfer moved while paused");
  ignore_sticks_a: assert property (
    state_q == ST_IGNORE |=> state_q inside {ST_IGNORE, ST_IDLE, ST_CMD}
      && !so_oe_o)
    else $error("ignored command left its phase");

  read_seen_c: cover property (state_q == ST_RDATA && so_oe_o);
  write_seen_c: cover property (mem_we);
  status_write_c: cover property (state_q == ST_WSR ##1 $changed(bp_q));
  pause_mid_read_c: cover property (
    state_q == ST_RDATA ##1 !pins.lvl[`SNV_PIN_HOLD_N]);
endmodule

// ---- test/snv_master_model.sv ----
// Behavioural SPI master that drives the memory's pins
`timescale 1ns/1ps
module snv_master_model (
  // Reference clock, used only to align frame starts
  input wire logic clk_sys_i,
  // Pins towards the memory
  output logic sck_o,
  output logic si_o,
  output logic cs_n_o,
  output logic wp_n_o,
  output logic hold_n_o,
  // Data-out pin and its enable from the memory
  input wire logic so_i,
  input wire logic so_oe_i
);
  localparam realtime HALF = 62.5; // Half of the 125 ns link period
  logic m3_q; // Clock idle level of the open frame
  logic last_q; // Last level read from the data-out wire
  // Idle pins: control high, clock low
  initial begin
    sck_o = 1'b0;
    si_o = 1'b0;
    cs_n_o = 1'b1;
    wp_n_o = 1'b1;
    hold_n_o = 1'b1;
    m3_q = 1'b0;
    last_q = 1'b0;
  end
  // Data in carries nothing between frames, so it keeps moving
  always #(HALF) if (cs_n_o) si_o = ~si_o;
  // Park the clock at the mode's idle level, then select
  task automatic sel(input logic m3);
    @(negedge clk_sys_i);
    m3_q = m3;
    sck_o = m3;
    #(HALF);
    cs_n_o = 1'b0;
    #(HALF);
  endtask
  // One byte each way, MSB first; the wire floats when not driven
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sck_o = 1'b0;
      si_o = tx[i];
      #(HALF);
      sck_o = 1'b1;
      rx[i] = so_oe_i ? so_i : ~last_q;
      last_q = rx[i];
      #(HALF);
    end
  endtask
  // Close the frame with the clock back at its idle level
  task automatic desel();
    sck_o = m3_q;
    #(HALF);
    cs_n_o = 1'b1;
    #(HALF);
    #(HALF);
  endtask
  // Pause with clock low, toggle the clock meanwhile, report enable
  task automatic pause(output logic oe);
    sck_o = 1'b0;
    #(HALF);
    hold_n_o = 1'b0;
    repeat (2) begin
      #(HALF);
      sck_o = 1'b1;
      #(HALF);
      sck_o = 1'b0;
    end
    #(HALF);
    oe = so_oe_i;
    hold_n_o = 1'b1;
    #(HALF);
  endtask
endmodule

// ---- test/tb.sv ----
// Self-checking bench for the serial memory slave
`timescale 1ns/1ps
module tb;
  import snv_pkg::*;
  logic clk_sys_i, sys_rst_i; // Clock and power-on reset
  logic sck, si, cs_n, wp_n, hold_n, so, so_oe, mode3; // Pins
  snv_byte_t status; // Status byte seen
  int failures, comparisons; // Counters
  logic [7:0] tx_q[$], rx_q[$]; // Bytes of one frame
  logic [7:0] mem_e [0:8191]; // Expected array
  logic wel_e, status_protect_enable_bit_e, wp_e, oe_seen; // Expected state, enable seen
  logic [1:0] bp_e; // Expected protect code
  snv_spi_mem snv_spi_mem_inst (.clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i), .sck_i(sck), .si_i(si), .cs_n_i(cs_n),
    .wp_n_i(wp_n), .hold_n_i(hold_n), .so_o(so), .so_oe_o(so_oe),
    .status_o(status), .mode3_o(mode3));
  snv_master_model mst (.clk_sys_i(clk_sys_i), .sck_o(sck), .si_o(si),
    .cs_n_o(cs_n), .wp_n_o(wp_n), .hold_n_o(hold_n), .so_i(so),
    .so_oe_i(so_oe));
  // 125 MHz clock
  always #4 clk_sys_i = ~clk_sys_i;
  // Remember any driven output within a frame
  always @(posedge clk_sys_i) if (so_oe === 1'b1) oe_seen = 1'b1;
  // Compare and count
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  // Expected status byte
  function automatic logic [7:0] st_e();
    return {status_protect_enable_bit_e, 3'h0, bp_e, wel_e, 1'b0};
  endfunction
  // Whether an address lies in the protected block
  function automatic logic prot(input logic [12:0] a);
    case (bp_e)
      2'h1: return a >= 13'h1800;
      2'h2: return a >= 13'h1000;
      2'h3: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction
  // Send tx_q as one frame, pausing before byte h
  task automatic frame(input logic m3, input int h);
    logic [7:0] r;
    logic p;
    rx_q.delete();
    oe_seen = 1'b0;
    mst.sel(m3);
    foreach (tx_q[i]) begin
      if (i == h) begin
        mst.pause(p);
        check("oe in pause", {7'h0, p}, 8'h00);
      end
      mst.xfer(tx_q[i], r);
      rx_q.push_back(r);
    end
    mst.desel();
    check("mode", {7'h0, mode3}, {7'h0, m3});
    check("oe idle", {7'h0, so_oe}, 8'h00);
    if (tx_q[0] != 8'h03 && tx_q[0] != 8'h05)
      check("oe no read", {7'h0, oe_seen}, 8'h00);
  endtask
  // Single-byte latch commands
  task automatic op1(input logic [7:0] op);
    tx_q = {op};
    if (op == 8'h06) wel_e = 1'b1;
    if (op == 8'h04) wel_e = 1'b0;
    frame(1'($urandom), -1);
    check("status", status, st_e());
  endtask
  // Status write, then read it back twice over the wire
  task automatic wrsr(input logic [7:0] v);
    tx_q = {8'h01, v};
    if (wel_e && !(status_protect_enable_bit_e && !wp_e)) begin
      status_protect_enable_bit_e = v[7];
      bp_e = v[3:2];
    end
    frame(1'b1, -1);
    check("status", status, st_e());
    tx_q = {8'h05, 8'h00, 8'h00};
    frame(1'b0, -1);
    check("rdsr 1", rx_q[1], st_e());
    check("rdsr 2", rx_q[2], st_e());
  endtask
  // Array write of n random bytes
  task automatic wr(input logic [15:0] a, input int n, input int h);
    logic [12:0] ad;
    logic [7:0] d;
    tx_q = {8'h02, a[15:8], a[7:0]};
    for (int i = 0; i < n; i++) begin
      ad = a[12:0] + 13'(i);
      d = 8'($urandom);
      tx_q.push_back(d);
      if (wel_e && !prot(ad)) mem_e[ad] = d;
    end
    frame(1'($urandom), h);
  endtask
  // Array read of n bytes, compared with the expected array
  task automatic rd(input logic [15:0] a, input int n);
    logic [12:0] ad;
    tx_q = {8'h03, a[15:8], a[7:0]};
    repeat (n) tx_q.push_back(8'($urandom));
    // Pause before the second data byte so output must resume mid-read
    frame(1'($urandom), n > 1 ? 4 : -1);
    for (int i = 0; i < n; i++) begin
      ad = a[12:0] + 13'(i);
      check("read", rx_q[3 + i], mem_e[ad]);
    end
  endtask
  // Counts and verdict
  task automatic summarize();
    $display("Comparisons %0d, failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Hang guard, well beyond the expected run
  initial begin
    #600000;
    failures++;
    summarize();
  end
  // Main sequence
  initial begin
    logic [15:0] a;
    logic [15:0] pa [4];
    int n;
    clk_sys_i = 1'b0;
    sys_rst_i = 1'b1;
    failures = 0;
    comparisons = 0;
    {wel_e, status_protect_enable_bit_e, wp_e, oe_seen, bp_e} = 6'b001000;
    void'($urandom(32'hC677DD13));
    repeat (16) @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
    repeat (8) @(negedge clk_sys_i);
    check("status rst", status, 8'h00);
    // Writes are dropped without the latch and after disable
    wr(16'h0040, 1, -1);
    op1(8'h06);
    wr(16'h0040, 2, -1);
    op1(8'h04);
    wr(16'h0040, 2, -1);
    rd(16'h0040, 2);
    // Unknown command: later bytes must not act as commands
    tx_q = {8'hFF, 8'h06, 8'h02};
    frame(1'b0, -1);
    check("status", status, st_e());
    op1(8'h06);
    // Random traffic, then a paused run wrapping past the top
    repeat (6) begin
      a = 16'($urandom);
      n = 1 + $urandom % 4;
      wr(a, n, -1);
      rd(a, n);
    end
    wr(16'hFFFE, 4, 4);
    rd(16'h1FFE, 4);
    // Each protect code on both sides of every boundary
    pa = '{16'h0FFF, 16'h1000, 16'h17FF, 16'h1800};
    foreach (pa[i]) wr(pa[i], 1, -1);
    for (int b = 1; b < 5; b++) begin
      wrsr({4'h0, 2'(b), 2'h0});
      foreach (pa[i]) begin
        wr(pa[i], 1, -1);
        rd(pa[i], 1);
      end
    end
    // Pin locks the status byte only, array writes still go
    wrsr(8'h84);
    wp_e = 1'b0;
    mst.wp_n_o = 1'b0;
    wrsr(8'h08);
    wr(16'h0123, 1, -1);
    rd(16'h0123, 1);
    wp_e = 1'b1;
    mst.wp_n_o = 1'b1;
    wrsr(8'h00);
    summarize();
  end
endmodule
